// >>> pkg/xbus_consts.vh
// Constants for the external parallel bus interface
`ifndef XBUS_CONSTS_VH
`define XBUS_CONSTS_VH

// Wait-state field positions and reset value (3-bit fields)
`define WS_FIELD_W 3
`define WS_PSL_LSB 0
`define WS_PSU_LSB 3
`define WS_DS_LSB 6
`define WS_IS_LSB 9
`define WS_CFG_W 12
`define WS_CFG_RESET 12'hfff

// Address bit that splits program space into lower and upper halves
`define PROG_UPPER_BIT 15

// Space codes
`define SPACE_PROG 2'h0
`define SPACE_DATA 2'h1
`define SPACE_IO 2'h2

// Sequencer states, one-hot
`define ST_IDLE 3'h1
`define ST_EXTERNAL_CYCLE_STROBE_N 3'h2
`define ST_TAIL 3'h4

// Access kinds, one-hot
`define KIND_WR 3'h1
`define KIND_RD 3'h2
`define KIND_PF 3'h4

// Clock timing: MCLK period and machine cycle length
`define MCLK_PERIOD_PS 8000
`define MACHINE_CYCLE_PS 16000
`define HALVES_PER_MC (`MACHINE_CYCLE_PS / `MCLK_PERIOD_PS)

`endif

// >>> hw/ready_sync.v
// Three-stage synchroniser with agreement filter for the ready pin
`timescale 1ns/100ps
module ready_sync (
	// Clock and reset
	input wire MCLK,
	input wire RST_B,
	// Pin in, filtered level out
	input wire PIN,
	output reg LEVEL
);
	reg s1_r;
	reg s2_r;
	reg s3_r;

	// Only the second stage reads the first; a change counts once stages two and three agree
	always @(posedge MCLK) begin
		if (!RST_B) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
			LEVEL <= 1'b1;
		end else begin
			s1_r <= PIN;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				LEVEL <= s3_r;
			end
		end
	end
endmodule

// >>> hw/wait_state_config.v
// Software wait-state configuration register
`timescale 1ns/100ps
`include "xbus_consts.vh"
module wait_state_config (
	// Clock and reset
	input wire MCLK,
	input wire RST_B,
	// Core write port
	input wire WE,
	input wire [15:0] WDATA,
	// Current configuration, upper bits read as zero
	output reg [15:0] CFG
);
	always @(posedge MCLK) begin
		if (!RST_B) begin
			CFG <= {4'h0, `WS_CFG_RESET};
		end else if (WE) begin
			CFG <= {4'h0, WDATA[`WS_CFG_W-1:0]};
		end
	end
endmodule

// >>> hw/ext_bus_if.v
// External parallel bus sequencer: program, data and I/O accesses on one bus
`timescale 1ns/100ps
`include "xbus_consts.vh"
module ext_bus_if #(
	parameter AW = 16,
	parameter DW = 16
) (
	// Clock and reset
	input wire MCLK,
	input wire RST_B,
	// Mode control
	input wire RD_FUNC_SEL,
	input wire CFG_WE,
	input wire [15:0] CFG_WDATA,
	output wire [15:0] WAIT_CFG,
	// Core data write request
	input wire WR_REQ,
	input wire [AW-1:0] WR_ADDR,
	input wire [DW-1:0] WR_DATA,
	input wire WR_IO,
	input wire WR_GLOBAL,
	output reg WR_DONE,
	// Core data read request
	input wire RD_REQ,
	input wire [AW-1:0] RD_ADDR,
	input wire RD_IO,
	input wire RD_GLOBAL,
	output reg RD_DONE,
	output reg [DW-1:0] RD_DATA,
	// Core program fetch request
	input wire PF_REQ,
	input wire [AW-1:0] PF_ADDR,
	output reg PF_DONE,
	output reg [DW-1:0] PF_DATA,
	// External address and space selects
	output reg [AW-1:0] ADDR,
	output reg PS_N,
	output reg DS_N,
	output reg IS_N,
	// External data bus
	input wire [DW-1:0] DATA_I,
	output reg [DW-1:0] DATA_O,
	output reg DATA_OE,
	// External control
	output reg RW,
	output reg EXTERNAL_CYCLE_STROBE_N_N,
	output reg RD_N,
	output reg WE_N,
	output reg BR_N,
	input wire READY
);
	reg [2:0] state_r;
	reg ph_r;
	reg [2:0] ws_r;
	reg need_rdy_r;
	reg [2:0] kind_r;
	reg [1:0] space_r;
	reg glob_r;
	reg [AW-1:0] addr_nxt;
	reg [DW-1:0] wdata_nxt;
	reg [2:0] kind_nxt;
	reg [1:0] space_nxt;
	reg glob_nxt;
	reg start_nxt;
	wire ready_s;
	wire [15:0] cfg;
	wire mc_end;
	wire any_done;

	// Programmed wait states for the space and address of an access
	function [2:0] ws_sel;
		input [15:0] c;
		input [1:0] sp;
		input [AW-1:0] a;
		begin
			case (sp)
			`SPACE_DATA: ws_sel = c[`WS_DS_LSB +: `WS_FIELD_W];
			`SPACE_IO: ws_sel = c[`WS_IS_LSB +: `WS_FIELD_W];
			default: begin
				if (a[`PROG_UPPER_BIT]) begin
					ws_sel = c[`WS_PSU_LSB +: `WS_FIELD_W];
				end else begin
					ws_sel = c[`WS_PSL_LSB +: `WS_FIELD_W];
				end
			end
			endcase
		end
	endfunction

	ready_sync u_ready_sync (
		.MCLK(MCLK),
		.RST_B(RST_B),
		.PIN(READY),
		.LEVEL(ready_s)
	);

	wait_state_config u_wait_cfg (
		.MCLK(MCLK),
		.RST_B(RST_B),
		.WE(CFG_WE),
		.WDATA(CFG_WDATA),
		.CFG(cfg)
	);

	assign WAIT_CFG = cfg;
	// Machine-cycle boundary: second half of the two-clock machine cycle
	assign mc_end = ph_r;
	// A request is still high in the cycle its done pulse shows; do not start it twice
	assign any_done = WR_DONE | RD_DONE | PF_DONE;

	// Pick the next access by priority; I/O differs from memory in its select and wait-state field, and never pulls BR_N low
	always @* begin
		start_nxt = 1'b0;
		kind_nxt = `KIND_PF;
		space_nxt = `SPACE_PROG;
		glob_nxt = 1'b0;
		addr_nxt = PF_ADDR;
		wdata_nxt = WR_DATA;
		if (!any_done) begin
			if (WR_REQ) begin
				start_nxt = 1'b1;
				kind_nxt = `KIND_WR;
				space_nxt = WR_IO ? `SPACE_IO : `SPACE_DATA;
				glob_nxt = WR_GLOBAL & ~WR_IO;
				addr_nxt = WR_ADDR;
			end else if (RD_REQ) begin
				start_nxt = 1'b1;
				kind_nxt = `KIND_RD;
				space_nxt = RD_IO ? `SPACE_IO : `SPACE_DATA;
				glob_nxt = RD_GLOBAL & ~RD_IO;
				addr_nxt = RD_ADDR;
			end else if (PF_REQ) begin
				start_nxt = 1'b1;
			end
		end
	end

	always @(posedge MCLK) begin
		if (!RST_B) begin
			// Synchronous reset drops every strobe at once, aborting any cycle
			state_r <= `ST_IDLE;
			ph_r <= 1'b0;
			ws_r <= 3'h0;
			need_rdy_r <= 1'b0;
			kind_r <= `KIND_PF;
			space_r <= `SPACE_PROG;
			glob_r <= 1'b0;
			ADDR <= {AW{1'b0}};
			PS_N <= 1'b1;
			DS_N <= 1'b1;
			IS_N <= 1'b1;
			DATA_O <= {DW{1'b0}};
			DATA_OE <= 1'b0;
			RW <= 1'b1;
			EXTERNAL_CYCLE_STROBE_N_N <= 1'b1;
			RD_N <= 1'b1;
			WE_N <= 1'b1;
			BR_N <= 1'b1;
			WR_DONE <= 1'b0;
			RD_DONE <= 1'b0;
			PF_DONE <= 1'b0;
			RD_DATA <= {DW{1'b0}};
			PF_DATA <= {DW{1'b0}};
		end else begin
			WR_DONE <= 1'b0;
			RD_DONE <= 1'b0;
			PF_DONE <= 1'b0;
			case (state_r)
			`ST_IDLE: begin
				ph_r <= 1'b0;
				EXTERNAL_CYCLE_STROBE_N_N <= 1'b1;
				WE_N <= 1'b1;
				DATA_OE <= 1'b0;
				BR_N <= 1'b1;
				PS_N <= 1'b1;
				DS_N <= 1'b1;
				IS_N <= 1'b1;
				RW <= 1'b1;
				RD_N <= RD_FUNC_SEL ? 1'b0 : 1'b1;
				if (start_nxt) begin
					state_r <= `ST_EXTERNAL_CYCLE_STROBE_N;
					kind_r <= kind_nxt;
					space_r <= space_nxt;
					glob_r <= glob_nxt;
					ADDR <= addr_nxt;
					DATA_O <= wdata_nxt;
					PS_N <= (space_nxt == `SPACE_PROG) ? 1'b0 : 1'b1;
					DS_N <= (space_nxt == `SPACE_DATA) ? 1'b0 : 1'b1;
					IS_N <= (space_nxt == `SPACE_IO) ? 1'b0 : 1'b1;
					RW <= (kind_nxt == `KIND_WR) ? 1'b0 : 1'b1;
					EXTERNAL_CYCLE_STROBE_N_N <= 1'b0;
					BR_N <= ~glob_nxt;
					ws_r <= ws_sel(cfg, space_nxt, addr_nxt);
					need_rdy_r <= (ws_sel(cfg, space_nxt, addr_nxt) != 3'h0);
					if (kind_nxt == `KIND_WR) begin
						RD_N <= RD_FUNC_SEL ? 1'b1 : 1'b1;
					end else begin
						RD_N <= 1'b0;
					end
				end
			end
			`ST_EXTERNAL_CYCLE_STROBE_N: begin
				ph_r <= ~ph_r;
				if (kind_r == `KIND_WR && !ph_r) begin
					// Drive the bus half a cycle after the strobe so a read driver can let go
					DATA_OE <= 1'b1;
					WE_N <= 1'b0;
				end
				if (mc_end) begin
					if (ws_r != 3'h0) begin
						ws_r <= ws_r - 3'h1;
					end else if (need_rdy_r && !ready_s) begin
						// No time-out: a device that never answers stalls the bus
						ws_r <= 3'h0;
					end else if (kind_r == `KIND_WR) begin
						state_r <= `ST_TAIL;
						EXTERNAL_CYCLE_STROBE_N_N <= 1'b1;
						WE_N <= 1'b1;
					end else begin
						state_r <= `ST_IDLE;
						EXTERNAL_CYCLE_STROBE_N_N <= 1'b1;
						BR_N <= 1'b1;
						PS_N <= 1'b1;
						DS_N <= 1'b1;
						IS_N <= 1'b1;
						RD_N <= RD_FUNC_SEL ? 1'b0 : 1'b1;
						if (kind_r == `KIND_RD) begin
							RD_DATA <= DATA_I;
							RD_DONE <= 1'b1;
						end else begin
							PF_DATA <= DATA_I;
							PF_DONE <= 1'b1;
						end
					end
				end
			end
			`ST_TAIL: begin
				// Second write cycle: hold data one half, then release the bus
				ph_r <= ~ph_r;
				if (!ph_r) begin
					DATA_OE <= 1'b0;
				end else begin
					state_r <= `ST_IDLE;
					WR_DONE <= 1'b1;
					BR_N <= 1'b1;
					PS_N <= 1'b1;
					DS_N <= 1'b1;
					IS_N <= 1'b1;
					RW <= 1'b1;
					RD_N <= RD_FUNC_SEL ? 1'b0 : 1'b1;
				end
			end
			default: begin
				state_r <= `ST_IDLE;
				ph_r <= 1'b0;
				EXTERNAL_CYCLE_STROBE_N_N <= 1'b1;
				WE_N <= 1'b1;
				DATA_OE <= 1'b0;
			end
			endcase
		end
	end
endmodule

// >>> tb/ext_bus_if_properties.sv
// Pin protocol checker for the external bus sequencer
`timescale 1ns/100ps
module ext_bus_if_properties (
	// Clock, reset, mode
	input wire MCLK, RST_B, RD_FUNC_SEL,
	// Completions
	input wire WR_DONE, RD_DONE, PF_DONE,
	// External bus
	input wire [15:0] ADDR,
	input wire DS_N, DATA_OE, RW, EXTERNAL_CYCLE_STROBE_N_N, RD_N, WE_N, BR_N
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_B);
	// Drivers turn on half a machine cycle late to avoid a fight
	sequence s_oe_late; !DATA_OE ##1 DATA_OE; endsequence
	sequence s_wr_tail; !DATA_OE ##1 WR_DONE; endsequence
	property p_rd_only; !RD_N && !RD_FUNC_SEL |-> RW && !EXTERNAL_CYCLE_STROBE_N_N; endproperty
	a_rd_only: assert property (p_rd_only) else $error("stray read strobe");
	property p_wr_only; !WE_N |-> !RW && !EXTERNAL_CYCLE_STROBE_N_N && DATA_OE; endproperty
	a_wr_only: assert property (p_wr_only) else $error("stray write strobe");
	property p_wr_turn; $fell(EXTERNAL_CYCLE_STROBE_N_N) && !RW |-> s_oe_late; endproperty
	a_wr_turn: assert property (p_wr_turn) else $error("bad drive start");
	property p_wr_end; $rose(EXTERNAL_CYCLE_STROBE_N_N) && !RW |=> s_wr_tail; endproperty
	a_wr_end: assert property (p_wr_end) else $error("bad write tail");
	property p_rd_end; $rose(EXTERNAL_CYCLE_STROBE_N_N) && RW |-> RD_DONE || PF_DONE; endproperty
	a_rd_end: assert property (p_rd_end) else $error("read not done");
	property p_br; $fell(BR_N) |-> $fell(DS_N) && $fell(EXTERNAL_CYCLE_STROBE_N_N); endproperty
	a_br: assert property (p_br) else $error("bus request off address");
	property p_hold;
		!EXTERNAL_CYCLE_STROBE_N_N && !$past(EXTERNAL_CYCLE_STROBE_N_N) |-> $stable(ADDR) && $stable(RW) && $stable(DS_N);
	endproperty
	a_hold: assert property (p_hold) else $error("address moved");
	property p_abort;
		disable iff (1'b0) !RST_B |=> EXTERNAL_CYCLE_STROBE_N_N && WE_N && BR_N && !DATA_OE;
	endproperty
	a_abort: assert property (p_abort) else $error("cycle not cut");
endmodule
bind ext_bus_if ext_bus_if_properties ext_bus_if_properties_inst (.MCLK(MCLK), .RST_B(RST_B),
	.RD_FUNC_SEL(RD_FUNC_SEL), .WR_DONE(WR_DONE), .RD_DONE(RD_DONE), .PF_DONE(PF_DONE),
	.ADDR(ADDR), .DS_N(DS_N), .DATA_OE(DATA_OE), .RW(RW), .EXTERNAL_CYCLE_STROBE_N_N(EXTERNAL_CYCLE_STROBE_N_N), .RD_N(RD_N),
	.WE_N(WE_N), .BR_N(BR_N));

// >>> tb/ext_mem_model.sv
// External memory and I/O device with a slow-ready option
`timescale 1ns/100ps
module ext_mem_model (
	input wire MCLK,
	input wire [15:0] ADDR,
	input wire DS_N, IS_N, EXTERNAL_CYCLE_STROBE_N_N, RD_N, WE_N, DATA_OE,
	input wire [15:0] DATA_O,
	input wire [7:0] SLOW,
	output logic [15:0] DATA_I,
	output logic READY
);
	logic [15:0] mem [64];
	logic [15:0] last = 16'h0;
	logic [7:0] cnt = 8'h0;
	wire [5:0] idx = {IS_N, DS_N, ADDR[3:0]};
	initial for (int i = 0; i < 64; i++) mem[i] = 16'h5a5a ^ (i[15:0] * 16'h0101);
	always @(posedge MCLK) begin
		cnt <= EXTERNAL_CYCLE_STROBE_N_N ? 8'h0 : cnt + 8'h1;
		last <= DATA_I;
		if (!WE_N && DATA_OE) mem[idx] <= DATA_O;
	end
	// Slow device holds ready low until its work is done, idle time included,
	// so the three-stage pin synchroniser already shows low when a cycle opens
	assign READY = EXTERNAL_CYCLE_STROBE_N_N ? (SLOW == 8'h0) : (cnt >= SLOW);
	// Released bus shows a changing pattern, never a stale word
	assign DATA_I = (!EXTERNAL_CYCLE_STROBE_N_N && !RD_N) ? mem[idx] : ~last;
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the external bus sequencer
`timescale 1ns/100ps
`define CHK(s, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
	$display("MISMATCH %s exp %0h got %0h", s, e, g); end end
module testbench;
	logic MCLK = 0, RST_B = 0, RD_FUNC_SEL = 0, CFG_WE = 0, WR_REQ = 0, RD_REQ = 0, PF_REQ = 0;
	logic WR_IO = 0, WR_GLOBAL = 0, RD_IO = 0, RD_GLOBAL = 0;
	logic [15:0] CFG_WDATA = 0, WR_ADDR = 0, WR_DATA = 0, RD_ADDR = 0, PF_ADDR = 0, v, a, d;
	wire [15:0] WAIT_CFG, RD_DATA, PF_DATA, ADDR, DATA_I, DATA_O;
	wire WR_DONE, RD_DONE, PF_DONE, PS_N, DS_N, IS_N, DATA_OE, RW, EXTERNAL_CYCLE_STROBE_N_N, RD_N, WE_N, BR_N;
	wire READY;
	logic [31:0] seed = 32'h5f26;
	logic [7:0] slow = 8'h0;
	int fails = 0, check_count = 0, cyc = 0, n, ord;
	ext_bus_if ext_bus_if_inst (.*);
	ext_mem_model ext_mem_model_inst (.*, .SLOW(slow));
	function logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	initial forever #4 MCLK = ~MCLK;
	always @(posedge MCLK) begin
		cyc++;
		if (cyc > 20000) begin
			fails++;
			conclude();
		end
	end
	task conclude;
		if (fails == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task step;
		@(posedge MCLK);
		#1;
	endtask
	task cfg(input logic [15:0] x);
		CFG_WDATA = x;
		CFG_WE = 1;
		step();
		CFG_WE = 0;
		step();
		`CHK("cfg", x & 16'h0fff, WAIT_CFG)
	endtask
	// Requests stay up until their own done pulse; ord records the finishing order
	task run(input logic [2:0] m);
		{WR_REQ, RD_REQ, PF_REQ} = m;
		n = 0;
		ord = 0;
		while ({WR_REQ, RD_REQ, PF_REQ} != 3'h0 && n < 300) begin
			step();
			n++;
			if (WR_DONE === 1'b1) begin WR_REQ = 0; ord = ord * 4 + 1; end
			if (RD_DONE === 1'b1) begin RD_REQ = 0; ord = ord * 4 + 2; end
			if (PF_DONE === 1'b1) begin PF_REQ = 0; ord = ord * 4 + 3; end
		end
		step();
	endtask
	task xfer(input logic io, input logic g, input int w);
		{WR_ADDR, WR_DATA, WR_IO, WR_GLOBAL} = {a, d, io, g};
		run(3'h4);
		`CHK("wr cycles", 5 + 2 * w, n)
		{RD_ADDR, RD_IO, RD_GLOBAL} = {a, io, g};
		run(3'h2);
		`CHK("rd cycles", 3 + 2 * w, n)
		`CHK("rd data", d, RD_DATA)
	endtask
	initial begin
		repeat (6) @(posedge MCLK);
		#1 RST_B = 1;
		`CHK("cfg reset", 16'h0fff, WAIT_CFG)
		{a, d} = {16'h0003, 16'h1234};
		xfer(0, 1, 7);
		for (int i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			v = (i == 0) ? 16'hf000 : seed[15:0];
			cfg(v);
			seed = lfsr(seed);
			{a, d} = seed;
			xfer(seed[3], seed[4], seed[3] ? v[11:9] : v[8:6]);
			PF_ADDR = a;
			run(3'h1);
			`CHK("pf cycles", 3 + 2 * (a[15] ? v[5:3] : v[2:0]), n)
			`CHK("pf data", 16'h5a5a ^ ({12'h003, a[3:0]} * 16'h0101), PF_DATA)
		end
		cfg(16'h0000);
		{WR_ADDR, RD_ADDR, WR_IO, RD_IO, PF_ADDR} = {16'h0001, 16'h0001, 2'b00, 16'h0002};
		run(3'h7);
		`CHK("order", 27, ord)
		`CHK("rd after wr", WR_DATA, RD_DATA)
		slow = 8'h14;
		run(3'h2);
		`CHK("ready ignored", 3, n)
		cfg(16'h0040);
		run(3'h2);
		`CHK("ready wait", 1'b1, n > 7 && n < 40 && n % 2 == 1)
		slow = 8'h0;
		cfg(16'h0000);
		{WR_ADDR, WR_DATA, WR_IO} = {16'h0009, 16'hc3c3, 1'b1};
		run(3'h4);
		WR_DATA = 16'h3c3c;
		WR_REQ = 1;
		step();
		{RST_B, WR_REQ} = 2'b00;
		step();
		step();
		`CHK("abort", 4'hf, {EXTERNAL_CYCLE_STROBE_N_N, WE_N, BR_N, ~DATA_OE})
		RST_B = 1;
		cfg(16'h0000);
		{RD_ADDR, RD_IO} = {16'h0009, 1'b1};
		run(3'h2);
		`CHK("abort data", 16'hc3c3, RD_DATA)
		RD_FUNC_SEL = 1;
		step();
		step();
		`CHK("rd pin idle", 1'b0, RD_N)
		run(3'h4);
		conclude();
	end
endmodule
